// file: ddcof_output_ports.sv
// Serial and parallel output ports of the dual-channel downconverter
`timescale 1ns/1ps
`default_nettype none
module ddcof_output_ports
  import ddcof_pkg::*;
(
  input wire logic clock, // 200 MHz chip clock
  input wire logic reset, // Synchronous, active high
  input wire ddcof_pkg::ddcof_set_t sample_set, // Decimated I/Q words
  input wire logic sample_valid, // Sample set offered
  output var logic sample_accept, // Room in the buffer
  input wire ddcof_pkg::ddcof_cfg_t cfg, // Port configuration
  input wire logic chain_data_in, // Serial data from chain slave
  input wire logic [2:0] parallel_segment_sel, // Segment select
  input wire logic parallel_output_enable_n, // Parallel enable, low
  output var logic sample_ready, // Period start pulse
  output var ddcof_pkg::ddcof_ser_t serial_pins, // Serial port pins
  output var logic [15:0] parallel_data, // Parallel segment
  output var logic parallel_data_oe // Parallel pins driven
);
  ddcof_st_t s_r;
  ddcof_st_t s_nxt;
  logic [SET_W-1:0] fifo_q;
  logic fifo_valid;
  logic pop;
  ddcof_set_t fmt_in;
  logic [CH_WORDS-1:0][31:0] fix_w;
  logic [CH_WORDS-1:0][3:0] exp_w;
  logic [CH_WORDS-1:0][7:0] man_w;
  logic [1:0][63:0] chv;
  logic [6:0] llen;
  logic [6:0] chlen;
  logic [6:0] wl;
  logic [8:0] ownv;
  logic [8:0] totv;
  logic [4:0] half_v;
  logic [2:0] rate;
  logic [127:0] vec_a;
  logic [127:0] vec_b;
  logic [1:0] widx;

  // Buffer absorbs bursts while a serial frame is still going out
  ddcof_fifo #(
    .W(SET_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .reset(reset),
    .in_data(sample_set),
    .in_valid(sample_valid),
    .in_ready(sample_accept),
    .out_data(fifo_q),
    .out_valid(fifo_valid),
    .out_ready(!s_r.busy)
  );

  // A new period starts when the engine is free and a set waits
  assign pop = fifo_valid && !s_r.busy;
  assign fmt_in = pop ? ddcof_set_t'(fifo_q) : s_r.smp;

  // One formatter per word of the sample set
  for (genvar g = 0; g < CH_WORDS; g++)
  begin : g_fmt
    ddcof_word_fmt u_fmt (
      .x(fmt_in.w[g]),
      .fmt(cfg.word_format),
      .fixed_word(fix_w[g]),
      .exponent(exp_w[g]),
      .mantissa(man_w[g])
    );
  end

  // Frame vectors, left-justified, built from the formatted words
  always_comb
  begin
    unique case (cfg.word_format)
      FMT_T8: llen = LEN_T8;
      FMT_R16: llen = LEN_R16;
      FMT_R24: llen = LEN_R24;
      FMT_F32: llen = LEN_F32;
      FMT_FLT: llen = LEN_FLT;
      default: llen = LEN_F32;
    endcase
    chlen = 7'(llen << 1);
    wl = cfg.packed_sel ? chlen : llen;
    for (int c = 0; c < 2; c++)
    begin
      if (cfg.word_format == FMT_FLT && cfg.packed_sel)
        chv[c] = {man_w[2*c], exp_w[2*c], exp_w[2*c+1], man_w[2*c+1],
                  40'h0000000000};
      else if (cfg.word_format == FMT_FLT)
        chv[c] = {man_w[2*c], exp_w[2*c], man_w[2*c+1], exp_w[2*c+1],
                  40'h0000000000};
      else
        chv[c] = {fix_w[2*c], 32'h00000000}
                 | ({fix_w[2*c+1], 32'h00000000} >> llen);
    end
    if (cfg.channel_multiplex_sel)
    begin
      vec_a = {chv[0], 64'h0} | ({chv[1], 64'h0} >> chlen);
      vec_b = '0;
      ownv = {1'b0, chlen, 1'b0};
    end
    else
    begin
      vec_a = {chv[0], 64'h0};
      vec_b = {chv[1], 64'h0};
      ownv = {2'b00, chlen};
    end
    // In multiplex mode the chain master appends the slave's stream after its own
    totv = (cfg.channel_multiplex_sel && cfg.chain_master_enable)
           ? 9'(ownv << 1) : ownv;
    rate = (cfg.serial_rate_sel > RATE_MAX) ? RATE_MAX : cfg.serial_rate_sel;
    // Flop-driven clock: divide by 1 and 2 both give a 2-cycle period
    half_v = (rate <= 3'h1) ? 5'h01 : 5'(5'h01 << (rate - 3'h1));
  end

  assign widx = parallel_segment_sel[2:1];

  // Next state: parallel segment, period start and serial shifter
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.rdy = 1'b0;
    s_nxt.ser.oe = cfg.serial_out_enable;
    s_nxt.poe = !parallel_output_enable_n;
    if (cfg.word_format == FMT_FLT)
      s_nxt.pdat = parallel_segment_sel[0] ? PAR_ZERO
                   : {4'h0, exp_w[widx], man_w[widx]};
    else if (parallel_segment_sel[0])
      s_nxt.pdat = fix_w[widx][15:0];
    else
      s_nxt.pdat = fix_w[widx][31:16];
    if (pop)
    begin
      s_nxt.smp = ddcof_set_t'(fifo_q);
      s_nxt.rdy = 1'b1;
      if (cfg.serial_out_enable)
      begin
        // First launch edge coincides with sample-ready
        s_nxt.busy = 1'b1;
        s_nxt.ph = 1'b1;
        s_nxt.fsa = 1'b1;
        s_nxt.cnt = 9'h001;
        s_nxt.wlen = wl;
        s_nxt.wcnt = wl - 7'h01;
        s_nxt.half = half_v;
        s_nxt.div = half_v - 5'h01;
        s_nxt.sh_a = vec_a;
        s_nxt.sh_b = vec_b;
        s_nxt.own = ownv;
        s_nxt.tot = totv;
        s_nxt.mux = cfg.channel_multiplex_sel;
        s_nxt.style = cfg.frame_pulse_style;
        s_nxt.ser.serial_data_first = 1'b0;
        s_nxt.ser.serial_data_second = 1'b0;
      end
    end
    else if (s_r.busy)
    begin
      if (s_r.div != 5'h00)
        s_nxt.div = s_r.div - 5'h01;
      else
      begin
        s_nxt.div = s_r.half - 5'h01;
        if (s_r.ph)
        begin
          // Capture edge; after the last bit the clock parks
          s_nxt.ph = 1'b0;
          if (s_r.cnt > s_r.tot)
          begin
            s_nxt.busy = 1'b0;
            s_nxt.fsa = 1'b0;
            s_nxt.ser.serial_data_first = 1'b0;
            s_nxt.ser.serial_data_second = 1'b0;
          end
        end
        else
        begin
          // Launch edge: strobe and data change here; elsewhere data only drops to zero as the clock parks
          s_nxt.ph = 1'b1;
          s_nxt.fsa = (s_r.wcnt == 7'h00) && (s_r.cnt < s_r.own)
                      && !s_r.style;
          s_nxt.wcnt = (s_r.wcnt == 7'h00) ? s_r.wlen - 7'h01
                       : s_r.wcnt - 7'h01;
          if (s_r.cnt <= s_r.own)
          begin
            s_nxt.ser.serial_data_first = s_r.sh_a[127];
            s_nxt.ser.serial_data_second = s_r.sh_b[127];
            s_nxt.sh_a = {s_r.sh_a[126:0], 1'b0};
            s_nxt.sh_b = {s_r.sh_b[126:0], 1'b0};
          end
          else
          begin
            s_nxt.ser.serial_data_first = chain_data_in;
            s_nxt.ser.serial_data_second = 1'b0;
          end
          s_nxt.cnt = 9'(s_r.cnt + 9'h001);
        end
      end
    end
    // Pin levels follow the polarity bits; idle clock rests at polarity
    s_nxt.ser.serial_clock = s_nxt.ph ^ cfg.serial_clock_polarity;
    s_nxt.ser.serial_frame_strobe = s_nxt.fsa
                                    ^ cfg.frame_strobe_polarity;
  end

  // State register
  always_ff @(posedge clock)
  begin
    if (reset)
      s_r <= ST_RST;
    else
      s_r <= s_nxt;
  end

  assign sample_ready = s_r.rdy;
  assign serial_pins = s_r.ser;
  assign parallel_data = s_r.pdat;
  assign parallel_data_oe = s_r.poe;

  default clocking @(posedge clock); endclocking
  default disable iff (reset);

  a_serial_tristate: assert property (
    !cfg.serial_out_enable |=> !serial_pins.oe)
    else $error("serial pins driven while disabled");
  a_ready_single: assert property (
    sample_ready |=> !sample_ready)
    else $error("sample-ready wider than one cycle");
  a_ready_strobe: assert property (
    sample_ready && s_r.busy |-> s_r.fsa && s_r.ph && s_r.cnt == 9'h001)
    else $error("strobe not coincident with sample-ready");
  a_style_single: assert property (
    s_r.busy && s_r.style && s_r.cnt > 9'h001 |-> !s_r.fsa)
    else $error("extra strobe in single-pulse style");
  a_mux_second_low: assert property (
    s_r.busy && s_r.mux |-> !serial_pins.serial_data_second)
    else $error("second pin not low in multiplex mode");
  a_launch_only: assert property (
    s_r.busy && $past(s_r.busy)
    && $changed(serial_pins.serial_data_first) |-> $rose(s_r.ph))
    else $error("data changed off the launch edge");
  a_rate_div8: assert property (
    $rose(s_r.ph) && s_r.half == 5'h04 |=> s_r.ph [*3] ##1 !s_r.ph)
    else $error("serial clock high phase not four cycles");
  a_stop_count: assert property (
    $fell(s_r.busy) |-> $past(s_r.cnt) == 9'($past(s_r.tot) + 9'h001))
    else $error("serial clock stopped at wrong bit count");
  a_par_tristate: assert property (
    parallel_output_enable_n |=> !parallel_data_oe)
    else $error("parallel pins driven while disabled");
  a_float_lower: assert property (
    cfg.word_format == FMT_FLT && parallel_segment_sel[0]
    |=> parallel_data == PAR_ZERO)
    else $error("float lower segment not zero");
  // Idle pins rest and enables follow one cycle later
  a_idle_parked: assert property (
    !s_r.busy |-> !s_r.ph)
    else $error("serial clock not parked while idle");
  a_idle_data_low: assert property (
    !s_r.busy |-> !serial_pins.serial_data_first)
    else $error("first data pin not low while idle");
  a_serial_drive: assert property (
    cfg.serial_out_enable |=> serial_pins.oe)
    else $error("serial pins not driven while enabled");
  a_par_drive: assert property (
    !parallel_output_enable_n |=> parallel_data_oe)
    else $error("parallel pins not driven while enabled");

  c_mux_frame: cover property ($fell(s_r.busy) && s_r.mux);
  c_chain_frame: cover property ($fell(s_r.busy) && s_r.tot != s_r.own);
  c_float_ready: cover property (sample_ready
    && cfg.word_format == FMT_FLT && s_r.busy);
  c_style_frame: cover property ($fell(s_r.busy) && s_r.style);
  c_par_float: cover property (parallel_data_oe
    && cfg.word_format == FMT_FLT);
endmodule
`default_nettype wire

// file: ddcof_pkg.sv
// Shared constants and types for the DDC output formatter ports
`default_nettype none
package ddcof_pkg;
  localparam int unsigned SMP_W = 32;
  localparam int unsigned CH_WORDS = 4;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned SET_W = SMP_W * CH_WORDS;
  localparam logic [2:0] RATE_MAX = 3'h5;
  // Serial bits per word for each format
  localparam logic [6:0] LEN_T8 = 7'h08;
  localparam logic [6:0] LEN_R16 = 7'h10;
  localparam logic [6:0] LEN_R24 = 7'h18;
  localparam logic [6:0] LEN_F32 = 7'h20;
  localparam logic [6:0] LEN_FLT = 7'h0C;
  localparam logic [3:0] EXP_MAX = 4'hF;
  localparam logic [31:0] POS_FULL = 32'h7FFFFFFF;
  localparam logic [31:0] HALF_R16 = 32'h00008000;
  localparam logic [31:0] HALF_R24 = 32'h00000080;
  localparam logic [31:0] MASK_R16 = 32'hFFFF0000;
  localparam logic [31:0] MASK_R24 = 32'hFFFFFF00;
  localparam logic [15:0] PAR_ZERO = 16'h0000;

  // Word format codes
  typedef enum logic [2:0] {
    FMT_T8 = 3'h0,
    FMT_R16 = 3'h1,
    FMT_R24 = 3'h2,
    FMT_F32 = 3'h3,
    FMT_FLT = 3'h4
  } ddcof_fmt_t;

  // Word order: 0 in-phase A, 1 quadrature A, 2 in-phase B, 3 quadrature B
  typedef struct packed {
    logic [CH_WORDS-1:0][SMP_W-1:0] w;
  } ddcof_set_t;

  typedef struct packed {
    logic serial_out_enable;
    logic channel_multiplex_sel;
    logic packed_sel;
    logic frame_pulse_style;
    logic serial_clock_polarity;
    logic frame_strobe_polarity;
    logic chain_master_enable;
    ddcof_fmt_t word_format;
    logic [2:0] serial_rate_sel;
  } ddcof_cfg_t;

  typedef struct packed {
    logic serial_clock;
    logic serial_frame_strobe;
    logic serial_data_first;
    logic serial_data_second;
    logic oe;
  } ddcof_ser_t;

  // Whole state of the port engine
  typedef struct packed {
    ddcof_set_t smp;
    logic [127:0] sh_a;
    logic [127:0] sh_b;
    logic [8:0] cnt;
    logic [8:0] own;
    logic [8:0] tot;
    logic [6:0] wlen;
    logic [6:0] wcnt;
    logic [4:0] half;
    logic [4:0] div;
    logic busy;
    logic ph;
    logic fsa;
    logic mux;
    logic style;
    logic rdy;
    logic [15:0] pdat;
    logic poe;
    ddcof_ser_t ser;
  } ddcof_st_t;

  localparam ddcof_st_t ST_RST = '0;
endpackage
`default_nettype wire

// file: ddcof_fifo.sv
// Sample-set FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module ddcof_fifo #(
  parameter int unsigned W = 128,
  parameter int unsigned DEPTH = 8
) (
  input wire logic clock, // System clock
  input wire logic reset, // Synchronous reset
  input wire logic [W-1:0] in_data, // Write data
  input wire logic in_valid, // Write request
  output var logic in_ready, // Not full
  output var logic [W-1:0] out_data, // Head word
  output var logic out_valid, // Not empty
  input wire logic out_ready // Drain request
);
  localparam int unsigned AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic full;
    logic empty;
    logic room;
  } ddcof_fifo_st_t;

  ddcof_fifo_st_t s_r;
  ddcof_fifo_st_t s_nxt;
  logic push;
  logic pop;

  // Full and empty are registered so both readies are clean
  always_comb
  begin
    s_nxt = s_r;
    push = in_valid && !s_r.full;
    pop = out_ready && !s_r.empty;
    if (push)
    begin
      s_nxt.mem[s_r.wp] = in_data;
      s_nxt.wp = s_r.wp + 1'b1;
    end
    if (pop)
      s_nxt.rp = s_r.rp + 1'b1;
    if (push && !pop)
      s_nxt.cnt = s_r.cnt + 1'b1;
    else if (pop && !push)
      s_nxt.cnt = s_r.cnt - 1'b1;
    s_nxt.full = (s_nxt.cnt == (AW+1)'(DEPTH));
    s_nxt.empty = (s_nxt.cnt == '0);
    // Ready to the producer leaves straight from a flop
    s_nxt.room = !s_nxt.full;
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      s_r <= '0;
      s_r.empty <= 1'b1;
      s_r.room <= 1'b1;
    end
    else
      s_r <= s_nxt;
  end

  assign in_ready = s_r.room;
  assign out_valid = !s_r.empty;
  assign out_data = s_r.mem[s_r.rp];

  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  a_fifo_no_overrun: assert property (s_r.full |=> !s_r.empty)
    else $error("fifo full then empty");
endmodule
`default_nettype wire

// file: ddcof_word_fmt.sv
// One-word number formatter: fixed point and 12-bit float
`timescale 1ns/1ps
`default_nettype none
module ddcof_word_fmt
  import ddcof_pkg::*;
(
  input wire logic [31:0] x, // Full-precision sample
  input wire ddcof_pkg::ddcof_fmt_t fmt, // Word format
  output var logic [31:0] fixed_word, // Left-justified fixed word
  output var logic [3:0] exponent, // Float exponent
  output var logic [7:0] mantissa // Float mantissa
);
  logic [3:0] lead;
  logic stop;
  logic [31:0] nrm;
  logic [31:0] r16;
  logic [31:0] r24;

  // Redundant sign bits set the exponent; capped at 15 shifts
  always_comb
  begin
    lead = 4'h0;
    stop = 1'b0;
    for (int i = 30; i >= 16; i--)
    begin
      if (!stop && (x[i] == x[31]))
        lead = lead + 4'h1;
      else
        stop = 1'b1;
    end
    exponent = EXP_MAX - lead;
    nrm = x << lead;
    mantissa = nrm[31:24];
    // Rounding saturates rather than wrapping to negative
    r16 = x + HALF_R16;
    r24 = x + HALF_R24;
    if (!x[31] && r16[31])
      r16 = POS_FULL;
    if (!x[31] && r24[31])
      r24 = POS_FULL;
    unique case (fmt)
      FMT_T8: fixed_word = {x[31:24], 24'h000000};
      FMT_R16: fixed_word = r16 & MASK_R16;
      FMT_R24: fixed_word = r24 & MASK_R24;
      FMT_F32: fixed_word = x;
      FMT_FLT: fixed_word = x;
      default: fixed_word = x;
    endcase
  end
endmodule
`default_nettype wire

// file: ddcof_dsp_rx.sv
// Behavioural DSP serial receiver that stands at the far side of the port
`timescale 1ns/1ps
`default_nettype none
module ddcof_dsp_rx (
  input wire logic clock, // Chip clock
  input wire ddcof_pkg::ddcof_ser_t pins, // Serial pins as driven
  input wire logic sclk_pol, // Serial clock polarity in use
  input wire logic fs_pol, // Frame strobe polarity in use
  output var logic chain_bit // Stand-in slave bit, flips per capture
);
  import ddcof_pkg::*;
  logic qa[$];
  logic qb[$];
  logic qs[$];
  int per_r;
  int gap_r;
  ddcof_ser_t prev_r;
  initial
  begin
    chain_bit = 1'b0;
    gap_r = 0;
    per_r = 0;
    prev_r = '0;
  end
  // Capture on the edge back to idle, opposite the launch edge
  // Data is taken from the cycle before, as the pins may drop at parking
  always @(posedge clock)
  begin
    gap_r <= gap_r + 1;
    if (prev_r.serial_clock == !sclk_pol && pins.serial_clock == sclk_pol)
    begin
      qa.push_back(prev_r.serial_data_first);
      qb.push_back(prev_r.serial_data_second);
      qs.push_back(prev_r.serial_frame_strobe ^ fs_pol);
      per_r <= gap_r + 1;
      gap_r <= 0;
      // Slave shifts on the master's capture edge, like a real chain
      chain_bit <= ~chain_bit;
    end
    prev_r <= pins;
  end
endmodule
`default_nettype wire

// file: ddcof_output_ports_test.sv
// Self-checking bench for the serial and parallel output ports
`timescale 1ns/1ps
`default_nettype none
module ddcof_output_ports_test;
  import ddcof_pkg::*;
  logic clock, reset, sample_valid, sample_accept, chain_data_in;
  logic sample_ready, pen_n, poe;
  logic [2:0] sel;
  logic [15:0] pdat;
  ddcof_set_t sample_set;
  ddcof_cfg_t cfg;
  ddcof_ser_t pins;
  int n_errors, cmp_count, cyc, nrdy, sent;
  logic exp_a[$];
  logic exp_b[$];
  logic exp_s[$];

  ddcof_output_ports dut (.clock(clock), .reset(reset),
    .sample_set(sample_set), .sample_valid(sample_valid),
    .sample_accept(sample_accept), .cfg(cfg),
    .chain_data_in(chain_data_in), .parallel_segment_sel(sel),
    .parallel_output_enable_n(pen_n), .sample_ready(sample_ready),
    .serial_pins(pins), .parallel_data(pdat), .parallel_data_oe(poe));
  ddcof_dsp_rx rx (.clock(clock), .pins(pins),
    .sclk_pol(cfg.serial_clock_polarity),
    .fs_pol(cfg.frame_strobe_polarity), .chain_bit(chain_data_in));

  // Chip clock, 5 ns period
  always #2.5 clock = ~clock;

  // Period count and hang ceiling
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (sample_ready === 1'b1)
      nrdy <= nrdy + 1;
    if (cyc == 30000)
    begin
      n_errors++;
      complete_run();
    end
  end

  task automatic complete_run();
    if (n_errors == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk_w(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Whole captured stream against the model, first difference reported, or bit 0 when the lengths differ
  task automatic chk_s(input string nm, input logic e[$], input logic g[$]);
    int bad;
    bad = (g.size() != e.size()) ? 0 : -1;
    for (int i = 0; i < e.size() && bad < 0; i++)
      if (g[i] !== e[i])
        bad = i;
    cmp_count++;
    if (bad >= 0)
    begin
      n_errors++;
      $display("ERROR %s bit %0d expected %b of %0d seen %b of %0d", nm,
               bad, e[bad], e.size(), g[bad], g.size());
    end
  endtask

  // Fixed word model, left-justified, rest zero
  function automatic logic [31:0] fx(input logic [31:0] x,
                                     input logic [2:0] f);
    logic [31:0] s;
    s = x + ((f == 3'h1) ? HALF_R16 : HALF_R24);
    if (!x[31] && s[31])
      s = POS_FULL;
    case (f)
      3'h0: return {x[31:24], 24'h000000};
      3'h1: return s & MASK_R16;
      3'h2: return s & MASK_R24;
      default: return x;
    endcase
  endfunction

  // Float model: exponent from redundant sign bits
  task automatic fl(input logic [31:0] x, output logic [3:0] e,
                    output logic [7:0] m);
    int r;
    logic [31:0] y;
    r = 0;
    while (r < 15 && x[30 - r] == x[31])
      r++;
    y = x << r;
    e = 4'hF - 4'(r);
    m = y[31:24];
  endtask

  function automatic ddcof_set_t rnd();
    ddcof_set_t r;
    logic signed [31:0] v;
    for (int i = 0; i < 4; i++)
    begin
      v = $urandom;
      r.w[i] = v >>> ($urandom % 31);
    end
    return r;
  endfunction

  task automatic put(input int p, input logic [31:0] v, input int n);
    for (int i = 0; i < n; i++)
      if (p == 0)
        exp_a.push_back(v[31 - i]);
      else
        exp_b.push_back(v[31 - i]);
  endtask

  // Expected captures: strobe slot first, then fields MSB first
  task automatic build(input ddcof_set_t s, input logic [2:0] f,
                       input logic mux, pk, sty, ch, c0);
    logic [3:0] e0, e1;
    logic [7:0] m0, m1;
    int L, wl, own, p;
    exp_a = {1'b0};
    exp_b = {1'b0};
    exp_s.delete();
    L = (f == 0) ? 8 : (f == 1) ? 16 : (f == 2) ? 24 : (f == 4) ? 12 : 32;
    for (int c = 0; c < 2; c++)
    begin
      p = (mux || c == 0) ? 0 : 1;
      fl(s.w[2 * c], e0, m0);
      fl(s.w[2 * c + 1], e1, m1);
      if (f == 3'h4)
      begin
        put(p, {m0, 24'h000000}, 8);
        put(p, {e0, 28'h0000000}, 4);
        put(p, pk ? {e1, 28'h0000000} : {m1, 24'h000000}, pk ? 4 : 8);
        put(p, pk ? {m1, 24'h000000} : {e1, 28'h0000000}, pk ? 8 : 4);
      end
      else
      begin
        put(p, fx(s.w[2 * c], f), L);
        put(p, fx(s.w[2 * c + 1], f), L);
      end
    end
    own = exp_a.size() - 1;
    // Relay slot k carries the slave bit after k capture flips
    if (ch && mux)
      for (int j = 1; j <= own; j++)
        exp_a.push_back(c0 ^ 1'((own + j) % 2));
    while (exp_b.size() < exp_a.size())
      exp_b.push_back(1'b0);
    wl = pk ? 2 * L : L;
    for (int k = 0; k < exp_a.size(); k++)
      exp_s.push_back(sty ? k == 0 : (k % wl == 0 && k < own));
  endtask

  // New settings, let idle levels settle, forget stray captures
  task automatic setup(input ddcof_cfg_t c);
    cfg <= c;
    repeat (3) @(posedge clock);
    rx.qa.delete();
    rx.qb.delete();
    rx.qs.delete();
  endtask

  // Offer a set and hold it until taken; valid stays up for the caller
  task automatic offer(input ddcof_set_t s);
    sample_set <= s;
    sample_valid <= 1'b1;
    do
      @(posedge clock);
    while (sample_accept !== 1'b1);
  endtask

  // Period start, then serial clock quiet for 70 cycles
  task automatic frame();
    int k, idle;
    logic pv;
    k = 0;
    while (sample_ready !== 1'b1 && k < 50)
    begin
      @(posedge clock);
      k++;
    end
    idle = 0;
    pv = pins.serial_clock;
    while (idle < 70)
    begin
      @(posedge clock);
      idle = (pins.serial_clock !== pv) ? 0 : idle + 1;
      pv = pins.serial_clock;
    end
  endtask

  task automatic run(input logic [2:0] f, input logic mux, pk, sty, scp,
                     fsp, ch, input logic [2:0] r);
    ddcof_set_t s;
    logic c0;
    int pe;
    s = rnd();
    setup({1'b1, mux, pk, sty, scp, fsp, ch, f, r});
    c0 = rx.chain_bit;
    offer(s);
    sample_valid <= 1'b0;
    frame();
    sent++;
    build(s, f, mux, pk, sty, ch, c0);
    // Divide by 1 cannot come from a flop, so it runs as 2
    pe = (r <= 3'h1) ? 2 : 1 << ((r > 3'h5) ? 5 : r);
    chk_w("serial period", pe, rx.per_r);
    chk_s("data first", exp_a, rx.qa);
    chk_s("data second", exp_b, rx.qb);
    chk_s("frame strobe", exp_s, rx.qs);
    chk_w("serial oe", 32'h1, {31'h0, pins.oe});
  endtask

  // Serial off; all eight segments read within one period
  task automatic par(input logic [2:0] f);
    ddcof_set_t s;
    logic [3:0] e;
    logic [7:0] m;
    logic [31:0] v;
    s = rnd();
    setup({7'h00, f, 3'h1});
    offer(s);
    sample_valid <= 1'b0;
    frame();
    sent++;
    chk_w("serial oe off", 32'h0, {31'h0, pins.oe});
    for (int i = 0; i < 8; i++)
    begin
      sel <= 3'(i);
      pen_n <= 1'b0;
      repeat (2) @(posedge clock);
      fl(s.w[i / 2], e, m);
      v = (f == 3'h4) ? {4'h0, e, m, 16'h0000} : fx(s.w[i / 2], f);
      v = {16'h0000, (i % 2) ? v[15:0] : v[31:16]};
      chk_w("parallel data", v, {16'h0000, pdat});
      chk_w("parallel oe", 32'h1, {31'h0, poe});
    end
    pen_n <= 1'b1;
    repeat (2) @(posedge clock);
    chk_w("parallel off", 32'h0, {31'h0, poe});
  endtask

  // Reset, seed, then every scenario in turn
  initial
  begin
    clock = 1'b0;
    reset = 1'b1;
    sample_valid = 1'b0;
    sample_set = '0;
    cfg = '0;
    sel = 3'h0;
    pen_n = 1'b1;
    void'($urandom(32'hE28A));
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    run(3'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 3'h1);
    run(3'h1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 3'h3);
    run(3'h2, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 3'h2);
    run(3'h4, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 3'h1);
    run(3'h4, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 3'h0);
    run(3'h7, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 3'h7);
    // Second reset in mid-run, serial pins, parallel enable and sample-ready back at rest
    reset <= 1'b1;
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    chk_w("reset outputs", 32'h0, {25'h0, pins, poe, sample_ready});
    run(3'h3, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 3'h2);
    par(3'h4);
    par(3'h2);
    par(3'h3);
    chk_w("ready count", sent, nrdy);
    complete_run();
  end
endmodule
`default_nettype wire
